//--- logic/lmx_pkg.sv
// constants, types and register map for the legacy mode exit and io check unit
package lmx_pkg;
  localparam int unsigned LMX_ADDR_W = 12;
  // apb register byte offsets
  localparam logic [11:0] LMX_REG_CTRL = 12'h000;
  localparam logic [11:0] LMX_REG_STAT = 12'h004;
  localparam logic [11:0] LMX_REG_MASK = 12'h008;
  localparam logic [11:0] LMX_REG_MODE = 12'h00c;
  localparam logic [11:0] LMX_REG_FLAGS = 12'h010;
  // flags register field positions
  localparam int unsigned LMX_FLAG_TRAP = 8;
  localparam int unsigned LMX_FLAG_IE = 9;
  localparam int unsigned LMX_FLAG_IO_PRIVILEGE_LEVEL_LO = 12;
  localparam int unsigned LMX_FLAG_NT = 14;
  localparam int unsigned LMX_FLAG_RESUME = 16;
  localparam int unsigned LMX_FLAG_EMU = 17;
  // control register bit zero of the mode extension enable
  localparam int unsigned LMX_CTRL_MEE = 0;
  localparam logic [1:0] LMX_USER_PL = 2'h3;
  localparam logic [1:0] LMX_SUPER_PL = 2'h0;
  localparam logic [31:0] LMX_FLAGS_RESET = 32'h0000_0002;
  // sticky event bits
  localparam int unsigned LMX_EV_GP = 0;
  localparam int unsigned LMX_EV_PF = 1;
  localparam int unsigned LMX_EV_PORT = 2;
  localparam int unsigned LMX_EV_EXIT = 3;
  localparam int unsigned LMX_EV_ENTER = 4;
  localparam int unsigned LMX_EV_W = 5;
  typedef enum logic [2:0] {
    LMX_OP_NONE, LMX_OP_CLI, LMX_OP_STI, LMX_OP_PUSH_FLAGS_OP, LMX_OP_POP_FLAGS_OP,
    LMX_OP_SWINT, LMX_OP_INTERRUPT_RETURN_OP, LMX_OP_HALT
  } lmx_op_t;
  typedef enum logic [1:0] {LMX_REAL, LMX_PROT, LMX_EMU} lmx_mode_t;
endpackage : lmx_pkg

//--- logic/lmx_port_check.sv
// port permission decision for one io access
`timescale 1ns/10ps
`default_nettype none
module lmx_port_check #(
  parameter int unsigned PORT_W = 4
) (
  input wire logic emu,
  input wire logic [1:0] current_privilege_level,
  input wire logic [1:0] io_privilege_level,
  input wire logic [PORT_W-1:0] port,
  input wire logic [(1<<PORT_W)-1:0] bitmap,
  output logic fault
);
  import lmx_pkg::*;
  always_comb begin
    if (emu) begin
      fault = bitmap[port]; // [RQ13] [RQ12]
    end else if (current_privilege_level <= io_privilege_level) begin
      fault = 1'b0; // [RQ14]
    end else begin
      fault = bitmap[port];
    end
  end
endmodule // lmx_port_check
`default_nettype wire

//--- logic/lmx_unit.sv
// legacy emulation mode exit, sensitive instruction and io permission checks
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// [RQ1] leave emulation only on interrupt or exception
// [RQ2] suspend interrupt enters protected mode via gate
// [RQ3] task switch reloads whole flags register
// [RQ4] new task emulated exactly when emulation flag
// [RQ5] handler return with flag resumes emulation
// [RQ6] unredirected software interrupt raises protection fault
// [RQ7] mode extension lets software interrupts redirect
// [RQ8] reset or init exits to real mode
// [RQ9] halt in emulation raises protection fault
// [RQ10] sensitive ops fault when io level below three
// [RQ11] privilege held at three while emulating
// [RQ12] port ops skip io level check
// [RQ13] emulated port access checked against bitmap
// [RQ14] protected port allowed when privilege within level
// [RQ15] not-present page access raises page fault
// [RQ16] gate entry clears emulation nested resume trap
// [RQ17] short segment task switch clears emulation flag
module lmx_unit #(
  parameter int unsigned PORT_W = 4
) (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic INIT_PIN,
  input wire logic HW_INT,
  input wire logic HW_INT_SUSPEND,
  input wire logic INT_GATE_TASK,
  input wire logic INT_GATE_IE,
  input wire logic OP_VALID,
  input wire lmx_pkg::lmx_op_t OP,
  input wire logic SWINT_REDIRECT,
  input wire logic PORT_VALID,
  input wire logic [PORT_W-1:0] PORT_ADDR,
  input wire logic [(1<<PORT_W)-1:0] PORT_BITMAP,
  input wire logic MEM_VALID,
  input wire logic MEM_PRESENT,
  input wire logic TASK_SWITCH,
  input wire logic TASK_SHORT_SEG,
  input wire logic [31:0] TASK_FLAGS,
  input wire logic HANDLER_RETURN,
  input wire logic [31:0] RETURN_FLAGS,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic GP_FAULT,
  output logic PAGE_FAULT,
  output logic SWINT_LOCAL,
  output lmx_pkg::lmx_mode_t MODE,
  output logic [1:0] CURRENT_PRIVILEGE_LEVEL,
  output logic [31:0] FLAGS,
  output logic IRQ
);
  import lmx_pkg::*;
  logic init_s1, init_s2, hw_s1, hw_s2, susp_s1, susp_s2;
  lmx_mode_t mode, next_mode;
  logic [31:0] flags, next_flags;
  logic [1:0] current_privilege_level, next_cpl;
  logic [31:0] ctrl, next_ctrl;
  logic [LMX_EV_W-1:0] stat, next_stat, mask, next_mask, ev;
  logic gp, next_gp, pf, next_pf, swl, next_swl;
  logic [31:0] prdata, next_prdata;
  logic emu, io_fault, sens, wr, rd, hit;
  logic [1:0] io_privilege_level;

  // pins from another domain pass two flops before use
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      init_s1 <= 1'b0;
      init_s2 <= 1'b0;
      hw_s1 <= 1'b0;
      hw_s2 <= 1'b0;
      susp_s1 <= 1'b0;
      susp_s2 <= 1'b0;
    end else begin
      init_s1 <= INIT_PIN;
      init_s2 <= init_s1;
      hw_s1 <= HW_INT;
      hw_s2 <= hw_s1;
      susp_s1 <= HW_INT_SUSPEND;
      susp_s2 <= susp_s1;
    end
  end

  assign emu = (mode == LMX_EMU);
  assign io_privilege_level = flags[LMX_FLAG_IO_PRIVILEGE_LEVEL_LO +: 2];

  lmx_port_check #(.PORT_W(PORT_W)) u_port (
    .emu(emu),
    .current_privilege_level(current_privilege_level),
    .io_privilege_level(io_privilege_level),
    .port(PORT_ADDR),
    .bitmap(PORT_BITMAP),
    .fault(io_fault)
  );

  assign wr = PSEL && PENABLE && PWRITE;
  assign rd = PSEL && !PENABLE && !PWRITE;
  assign hit = (PADDR == LMX_REG_CTRL) || (PADDR == LMX_REG_STAT)
    || (PADDR == LMX_REG_MASK) || (PADDR == LMX_REG_MODE) || (PADDR == LMX_REG_FLAGS);

  always_comb begin
    next_mode = mode;
    next_flags = flags;
    next_cpl = current_privilege_level;
    next_gp = 1'b0;
    next_pf = 1'b0;
    next_swl = 1'b0;
    ev = '0;
    sens = 1'b0;
    if (OP_VALID) begin
      case (OP)
        LMX_OP_CLI, LMX_OP_STI, LMX_OP_PUSH_FLAGS_OP, LMX_OP_POP_FLAGS_OP, LMX_OP_INTERRUPT_RETURN_OP: sens = 1'b1;
        default: sens = 1'b0;
      endcase
    end
    if (init_s2) begin
      next_mode = LMX_REAL; // [RQ8]
      next_flags = LMX_FLAGS_RESET;
      next_cpl = LMX_SUPER_PL;
      ev[LMX_EV_EXIT] = emu;
    end else if (TASK_SWITCH) begin
      next_flags = TASK_FLAGS; // [RQ3]
      if (TASK_SHORT_SEG) begin
        next_flags[31:16] = 16'h0000; // [RQ17]
      end
      // [RQ4]
      next_mode = (next_flags[LMX_FLAG_EMU]) ? LMX_EMU : LMX_PROT;
      next_cpl = (next_flags[LMX_FLAG_EMU]) ? LMX_USER_PL : LMX_SUPER_PL;
      ev[LMX_EV_EXIT] = emu && !next_flags[LMX_FLAG_EMU];
      ev[LMX_EV_ENTER] = !emu && next_flags[LMX_FLAG_EMU];
    end else if (HANDLER_RETURN && mode == LMX_PROT) begin
      next_flags = RETURN_FLAGS; // [RQ5]
      next_mode = RETURN_FLAGS[LMX_FLAG_EMU] ? LMX_EMU : LMX_PROT;
      next_cpl = RETURN_FLAGS[LMX_FLAG_EMU] ? LMX_USER_PL : current_privilege_level;
      ev[LMX_EV_ENTER] = RETURN_FLAGS[LMX_FLAG_EMU];
    end else if (emu) begin
      // faults and interrupts are the only exits
      if (OP_VALID && OP == LMX_OP_HALT) begin
        next_gp = 1'b1; // [RQ9]
      end else if (sens && io_privilege_level < LMX_USER_PL) begin
        next_gp = 1'b1; // [RQ10]
      end else if (OP_VALID && OP == LMX_OP_SWINT) begin
        if (ctrl[LMX_CTRL_MEE] && SWINT_REDIRECT) begin
          next_swl = 1'b1; // [RQ7]
        end else begin
          next_gp = 1'b1; // [RQ6]
        end
      end
      if (PORT_VALID && io_fault) begin
        next_gp = 1'b1; // [RQ13]
        ev[LMX_EV_PORT] = 1'b1;
      end
      if (MEM_VALID && !MEM_PRESENT) begin
        next_pf = 1'b1; // [RQ15]
      end
      if (next_gp || next_pf || hw_s2 || susp_s2) begin
        next_mode = LMX_PROT; // [RQ1] [RQ2]
        next_cpl = LMX_SUPER_PL;
        if (!INT_GATE_TASK) begin
          // [RQ16]
          next_flags[LMX_FLAG_EMU] = 1'b0;
          next_flags[LMX_FLAG_NT] = 1'b0;
          next_flags[LMX_FLAG_RESUME] = 1'b0;
          next_flags[LMX_FLAG_TRAP] = 1'b0;
          if (INT_GATE_IE) begin
            next_flags[LMX_FLAG_IE] = 1'b0;
          end
        end
        ev[LMX_EV_EXIT] = 1'b1;
      end else begin
        next_cpl = LMX_USER_PL; // [RQ11]
      end
    end else if (PORT_VALID && io_fault) begin
      next_gp = 1'b1; // [RQ14]
      ev[LMX_EV_PORT] = 1'b1;
    end
    ev[LMX_EV_GP] = next_gp;
    ev[LMX_EV_PF] = next_pf;
    next_ctrl = ctrl;
    next_mask = mask;
    if (wr && PADDR == LMX_REG_CTRL) begin
      next_ctrl = PWDATA;
    end
    if (wr && PADDR == LMX_REG_MASK) begin
      next_mask = PWDATA[LMX_EV_W-1:0];
    end
    // set wins over a same-cycle write-one clear
    next_stat = stat;
    if (wr && PADDR == LMX_REG_STAT) begin
      next_stat = stat & ~PWDATA[LMX_EV_W-1:0];
    end
    next_stat = next_stat | ev;
    next_prdata = prdata;
    if (rd) begin
      case (PADDR)
        LMX_REG_CTRL: next_prdata = ctrl;
        LMX_REG_STAT: next_prdata = {{(32-LMX_EV_W){1'b0}}, stat};
        LMX_REG_MASK: next_prdata = {{(32-LMX_EV_W){1'b0}}, mask};
        LMX_REG_MODE: next_prdata = {28'h0000000, current_privilege_level, mode};
        LMX_REG_FLAGS: next_prdata = flags;
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mode <= LMX_REAL; // [RQ8]
      flags <= LMX_FLAGS_RESET;
      current_privilege_level <= LMX_SUPER_PL;
      ctrl <= 32'h0000_0000;
      stat <= '0;
      mask <= '0;
      gp <= 1'b0;
      pf <= 1'b0;
      swl <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      mode <= next_mode;
      flags <= next_flags;
      current_privilege_level <= next_cpl;
      ctrl <= next_ctrl;
      stat <= next_stat;
      mask <= next_mask;
      gp <= next_gp;
      pf <= next_pf;
      swl <= next_swl;
      prdata <= next_prdata;
    end
  end

  // setup cycle latches read data, so access completes at once
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !hit;
  assign PRDATA = prdata;
  assign GP_FAULT = gp;
  assign PAGE_FAULT = pf;
  assign SWINT_LOCAL = swl;
  assign MODE = mode;
  assign CURRENT_PRIVILEGE_LEVEL = current_privilege_level;
  assign FLAGS = flags;
  assign IRQ = |(stat & mask);

  chk_halt_faults: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [RQ9]
    (emu && OP_VALID && OP == LMX_OP_HALT && !init_s2 && !TASK_SWITCH) |=> GP_FAULT)
    else $error("halt did not fault");
  chk_emu_cpl_three: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [RQ11]
    (MODE == LMX_EMU) |-> (CURRENT_PRIVILEGE_LEVEL == LMX_USER_PL))
    else $error("cpl not three while emulating");
  chk_init_real: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [RQ8]
    init_s2 |=> (MODE == LMX_REAL))
    else $error("init did not enter real mode");
  chk_exit_cause: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [RQ1]
    ($past(mode) == LMX_EMU && mode == LMX_PROT) |-> ($past(next_gp) || $past(next_pf)
      || $past(hw_s2) || $past(susp_s2) || $past(TASK_SWITCH)))
    else $error("emulation left without cause");
  chk_switch_mode: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [RQ4]
    (TASK_SWITCH && !init_s2 && !TASK_SHORT_SEG) |=>
      ((MODE == LMX_EMU) == FLAGS[LMX_FLAG_EMU]))
    else $error("task mode does not follow flag");
  chk_short_seg: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [RQ17]
    (TASK_SWITCH && !init_s2 && TASK_SHORT_SEG) |=> (MODE != LMX_EMU))
    else $error("short segment kept emulation");
  chk_sens_fault: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [RQ10]
    (emu && sens && io_privilege_level < LMX_USER_PL && !init_s2 && !TASK_SWITCH) |=> GP_FAULT)
    else $error("sensitive op did not fault");
  chk_page_fault: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [RQ15]
    (emu && MEM_VALID && !MEM_PRESENT && !init_s2 && !TASK_SWITCH) |=> PAGE_FAULT)
    else $error("missing page fault");
  chk_redirect: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [RQ7]
    SWINT_LOCAL |-> (ctrl[LMX_CTRL_MEE] && MODE == LMX_EMU))
    else $error("redirect without mode extension");
  chk_gate_clear: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [RQ16]
    ($past(mode) == LMX_EMU && mode == LMX_PROT && !$past(INT_GATE_TASK)
      && !$past(TASK_SWITCH)) |-> (!FLAGS[LMX_FLAG_EMU] && !FLAGS[LMX_FLAG_TRAP]))
    else $error("gate entry kept flags");
  cov_enter: cover property (@(posedge REF_CLK) disable iff (SYS_RST) stat[LMX_EV_ENTER]);
  cov_gp: cover property (@(posedge REF_CLK) disable iff (SYS_RST) GP_FAULT);
  cov_local: cover property (@(posedge REF_CLK) disable iff (SYS_RST) SWINT_LOCAL);
  cov_irq: cover property (@(posedge REF_CLK) disable iff (SYS_RST) IRQ);
endmodule // lmx_unit
`default_nettype wire

//--- testbench/lmx_irq_src.sv
// interrupt source model for the hardware interrupt lines
`timescale 1ns/10ps
`default_nettype none
module lmx_irq_src #(
  parameter int HOLD = 6
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  input wire logic kind,
  output logic hw_int,
  output logic hw_int_suspend
);
  int cnt;
  logic k;
  // level held long enough to cross the unit's synchroniser
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      k <= 1'b0;
    end else if (req) begin
      cnt <= HOLD;
      k <= kind;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
  assign hw_int = (cnt != 0) && !k;
  assign hw_int_suspend = (cnt != 0) && k;
endmodule // lmx_irq_src
`default_nettype wire

//--- testbench/lmx_unit_tb.sv
// self-checking bench for the legacy mode exit unit
`timescale 1ns/10ps
`default_nettype none
module lmx_unit_tb;
  import lmx_pkg::*;
  logic REF_CLK, SYS_RST, INIT_PIN, HW_INT, HW_INT_SUSPEND, INT_GATE_IE, OP_VALID;
  logic SWINT_REDIRECT, PORT_VALID, MEM_VALID, MEM_PRESENT, TASK_SWITCH, TASK_SHORT_SEG;
  logic HANDLER_RETURN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, GP_FAULT, PAGE_FAULT;
  logic SWINT_LOCAL, IRQ, irq_req, irq_kind, a, err, INT_GATE_TASK;
  lmx_op_t OP;
  lmx_mode_t MODE;
  logic [1:0] CURRENT_PRIVILEGE_LEVEL;
  logic [3:0] PORT_ADDR;
  logic [15:0] PORT_BITMAP;
  logic [11:0] PADDR;
  logic [31:0] TASK_FLAGS, RETURN_FLAGS, PWDATA, PRDATA, FLAGS, rd;
  int fails, n_checks, hits, j;
  lmx_unit #(.PORT_W(4)) DUT (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .INIT_PIN(INIT_PIN),
    .HW_INT(HW_INT), .HW_INT_SUSPEND(HW_INT_SUSPEND), .INT_GATE_TASK(INT_GATE_TASK),
    .INT_GATE_IE(INT_GATE_IE), .OP_VALID(OP_VALID), .OP(OP), .SWINT_REDIRECT(SWINT_REDIRECT),
    .PORT_VALID(PORT_VALID), .PORT_ADDR(PORT_ADDR), .PORT_BITMAP(PORT_BITMAP),
    .MEM_VALID(MEM_VALID), .MEM_PRESENT(MEM_PRESENT), .TASK_SWITCH(TASK_SWITCH),
    .TASK_SHORT_SEG(TASK_SHORT_SEG), .TASK_FLAGS(TASK_FLAGS), .HANDLER_RETURN(HANDLER_RETURN),
    .RETURN_FLAGS(RETURN_FLAGS), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .GP_FAULT(GP_FAULT), .PAGE_FAULT(PAGE_FAULT), .SWINT_LOCAL(SWINT_LOCAL), .MODE(MODE),
    .CURRENT_PRIVILEGE_LEVEL(CURRENT_PRIVILEGE_LEVEL), .FLAGS(FLAGS), .IRQ(IRQ));
  lmx_irq_src #(.HOLD(6)) src (.clk(REF_CLK), .rst(SYS_RST), .req(irq_req),
    .kind(irq_kind), .hw_int(HW_INT), .hw_int_suspend(HW_INT_SUSPEND));
  initial begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // clears the op, port, mem, task switch and handler return requests after the edge that takes them
  task fire;
    @(posedge REF_CLK);
    OP_VALID <= 1'b0;
    PORT_VALID <= 1'b0;
    MEM_VALID <= 1'b0;
    TASK_SWITCH <= 1'b0;
    TASK_SHORT_SEG <= 1'b0;
    HANDLER_RETURN <= 1'b0;
    #1;
  endtask
  task op(input lmx_op_t o);
    @(posedge REF_CLK);
    OP_VALID <= 1'b1;
    OP <= o;
    fire;
  endtask
  task enter_emu(input logic [31:0] f);
    @(posedge REF_CLK);
    TASK_FLAGS <= f;
    TASK_SWITCH <= 1'b1;
    fire;
    chk(MODE, LMX_EMU);
    chk(CURRENT_PRIVILEGE_LEVEL, 2'h3);
    chk(FLAGS, f);
  endtask
  task port(input logic [15:0] bm);
    @(posedge REF_CLK);
    PORT_ADDR <= 4'h5;
    PORT_BITMAP <= bm;
    PORT_VALID <= 1'b1;
    fire;
  endtask
  task mem(input logic p);
    @(posedge REF_CLK);
    MEM_PRESENT <= p;
    MEM_VALID <= 1'b1;
    fire;
  endtask
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int i;
    @(posedge REF_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= ad;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    i = 0;
    @(posedge REF_CLK);
    while (PREADY !== 1'b1) begin
      i++;
      if (i > 20) begin
        fails++;
        give_verdict;
      end
      @(posedge REF_CLK);
    end
    // answer taken at the edge that samples ready, then released
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task wait_mode(input lmx_mode_t m);
    int i;
    for (i = 0; i < 20 && MODE !== m; i++) begin
      @(negedge REF_CLK);
    end
    if (MODE !== m) begin
      fails++;
      give_verdict;
    end
  endtask
  initial begin
    {SYS_RST, INIT_PIN, INT_GATE_IE, OP_VALID, SWINT_REDIRECT, PORT_VALID} = 6'h20;
    {MEM_VALID, MEM_PRESENT, TASK_SWITCH, TASK_SHORT_SEG, HANDLER_RETURN} = 5'h0;
    {PSEL, PENABLE, PWRITE, irq_req, irq_kind, INT_GATE_TASK} = 6'h0;
    {OP, PORT_ADDR, PORT_BITMAP, PADDR} = '0;
    {TASK_FLAGS, RETURN_FLAGS, PWDATA} = '0;
    fails = 0;
    n_checks = 0;
    repeat (6) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    #1;
    chk(MODE, LMX_REAL);
    chk(FLAGS, LMX_FLAGS_RESET);
    @(posedge REF_CLK);
    TASK_SHORT_SEG <= 1'b1;
    TASK_FLAGS <= 32'h0002_3002;
    TASK_SWITCH <= 1'b1;
    fire;
    chk(FLAGS, 32'h0000_3002);
    chk(MODE, LMX_PROT);
    for (j = 1; j < 8; j++) begin
      enter_emu(32'h0002_0002);
      op(lmx_op_t'(j));
      chk(GP_FAULT, 1'b1);
      chk(MODE, LMX_PROT);
      chk(FLAGS, 32'h0000_0002);
    end
    // task gate dispatch leaves the flags image alone
    enter_emu(32'h0002_0002);
    INT_GATE_TASK <= 1'b1;
    op(LMX_OP_HALT);
    chk(MODE, LMX_PROT);
    chk(FLAGS, 32'h0002_0002);
    INT_GATE_TASK <= 1'b0;
    for (j = 1; j < 7; j++) begin
      if (j != 5) begin
        enter_emu(32'h0002_3002);
        op(lmx_op_t'(j));
        chk(GP_FAULT, 1'b0);
        chk(MODE, LMX_EMU);
      end
    end
    // redirect bit high keeps the software interrupt local
    apb(1'b1, LMX_REG_CTRL, 32'h1);
    hits = 0;
    for (j = 0; j < 2; j++) begin
      enter_emu(32'h0002_0002);
      @(posedge REF_CLK);
      SWINT_REDIRECT <= j[0];
      OP_VALID <= 1'b1;
      OP <= LMX_OP_SWINT;
      fire;
      hits += (SWINT_LOCAL === 1'b1 && MODE === LMX_EMU);
      chk(SWINT_LOCAL, j[0]);
      chk(MODE, j[0] ? LMX_EMU : LMX_PROT);
    end
    chk(hits, 1);
    apb(1'b1, LMX_REG_CTRL, 32'h0);
    enter_emu(32'h0002_0002);
    port(16'h0000);
    chk(MODE, LMX_EMU);
    port(16'h0020);
    chk(MODE, LMX_PROT);
    apb(1'b1, LMX_REG_STAT, 32'h1f);
    port(16'h0020);
    apb(1'b0, LMX_REG_STAT, 32'h0);
    chk(rd[2], 1'b0);
    enter_emu(32'h0002_0002);
    mem(1'b1);
    chk(PAGE_FAULT, 1'b0);
    mem(1'b0);
    chk(PAGE_FAULT, 1'b1);
    chk(MODE, LMX_PROT);
    @(posedge REF_CLK);
    RETURN_FLAGS <= 32'h0002_0202;
    HANDLER_RETURN <= 1'b1;
    fire;
    chk(MODE, LMX_EMU);
    chk(CURRENT_PRIVILEGE_LEVEL, 2'h3);
    apb(1'b0, LMX_REG_MODE, 32'h0);
    chk(rd, 32'h0000_000e);
    apb(1'b0, LMX_REG_FLAGS, 32'h0);
    chk(rd, 32'h0002_0202);
    for (j = 0; j < 2; j++) begin
      enter_emu(32'h0006_4302);
      @(posedge REF_CLK);
      INT_GATE_IE <= j[0];
      irq_kind <= j[0];
      irq_req <= 1'b1;
      @(posedge REF_CLK);
      irq_req <= 1'b0;
      wait_mode(LMX_PROT);
      chk(FLAGS, j ? 32'h0004_0002 : 32'h0004_0202);
      chk(CURRENT_PRIVILEGE_LEVEL, 2'h0);
      // let the held level drain through the synchroniser
      repeat (10) @(posedge REF_CLK);
    end
    apb(1'b1, LMX_REG_MASK, 32'h0);
    @(negedge REF_CLK);
    a = IRQ;
    apb(1'b1, LMX_REG_MASK, 32'h1f);
    @(negedge REF_CLK);
    chk(a ^ IRQ, 1'b1);
    apb(1'b1, LMX_REG_STAT, 32'h1f);
    apb(1'b0, LMX_REG_STAT, 32'h0);
    chk(rd, 32'h0);
    chk(IRQ, 1'b0);
    apb(1'b0, 12'h020, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    enter_emu(32'h0002_0002);
    @(posedge REF_CLK);
    INIT_PIN <= 1'b1;
    wait_mode(LMX_REAL);
    chk(CURRENT_PRIVILEGE_LEVEL, 2'h0);
    give_verdict;
  end
endmodule // lmx_unit_tb
`default_nettype wire
